// [tcg_core.sv]
`timescale 1ns/1ps
`default_nettype none
module tcg_core #(
    parameter int CLK_HZ = tcg_pkg::CLK_HZ_DEF,
    parameter int LOSS_MS = tcg_pkg::LOSS_MS_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic ext_tc_valid,
    input wire tcg_pkg::tcg_tc_s ext_tc_value,
    input wire logic rec_active,
    output tcg_pkg::tcg_tc_s tc_out,
    output logic [31:0] ubits_out,
    output logic tc_running,
    output logic record_req,
    output logic audio_clk_ext
);
    import tcg_pkg::*;

    localparam int TENTH_CYC = CLK_HZ / 1000 * DELAY_STEP_MS;
    localparam int LOSS_CYC = CLK_HZ / 1000 * LOSS_MS;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    tcg_mode_e mode_reg;
    tcg_rate_e rate_reg;
    tcg_umode_e umode_reg;
    logic sync_en_reg;
    logic cont_en_reg;
    tcg_tc_s restart_reg;
    logic [31:0] user_reg;
    logic [23:0] rtc_reg;
    logic [6:0] delay_reg;
    tcg_tc_s tc_reg;
    tcg_tc_s ext_last_reg;
    logic [31:0] loss_cnt_reg;
    logic ext_present_reg;
    logic [31:0] pre_reg;
    logic [6:0] tenths_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [31:0] addr_reg;
    logic ext_mode;
    logic date_mode;
    logic run;
    logic frame_tick;
    logic wr_ctrl;
    logic wr_ubits;
    logic wr_jam;
    logic wr_restart;
    logic [31:0] rd_data;
    tcg_mode_e new_mode;

    // Address phase capture, reads take one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
            rd_pend_reg <= hsel && htrans[1] && hready && !hwrite;
            hreadyout <= !(hsel && htrans[1] && hready && !hwrite);
            hresp <= 1'b0;
            if (hsel && htrans[1] && hready) begin
                addr_reg <= haddr;
            end
        end
    end

    // Data phase write strobes
    assign wr_ctrl = wr_pend_reg && addr_reg == {24'h00_0000, OFF_CTRL};
    assign wr_ubits = wr_pend_reg && addr_reg == {24'h00_0000, OFF_UBITS};
    assign wr_jam = wr_pend_reg && addr_reg == {24'h00_0000, OFF_CMD}
        && hwdata[CMD_JAM_BIT];
    assign wr_restart = wr_pend_reg && addr_reg == {24'h00_0000, OFF_CMD}
        && hwdata[CMD_RESTART_BIT];

    assign ext_mode = mode_reg == MODE_EXT || mode_reg == MODE_EXT_AUTO;
    assign date_mode = umode_reg != UB_FREE;

    // Mode code check on write, illegal codes fall back to off
    always_comb begin
        unique case (hwdata[CTRL_MODE_LSB +: 3])
            3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101:
                new_mode = tcg_mode_e'(hwdata[CTRL_MODE_LSB +: 3]);
            default: new_mode = MODE_OFF;
        endcase
    end

    // Control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= MODE_OFF;
            rate_reg <= RATE_30;
            umode_reg <= UB_FREE;
            sync_en_reg <= 1'b0;
            cont_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            mode_reg <= new_mode;
            if (hwdata[CTRL_RATE_LSB +: 3] != 3'b111) begin
                rate_reg <= tcg_rate_e'(hwdata[CTRL_RATE_LSB +: 3]);
            end
            umode_reg <= tcg_umode_e'(hwdata[CTRL_UMODE_LSB +: 2]);
            sync_en_reg <= hwdata[CTRL_SYNC_BIT]
                && (new_mode == MODE_EXT || new_mode == MODE_EXT_AUTO);
            cont_en_reg <= hwdata[CTRL_CONT_BIT]
                && (new_mode == MODE_EXT || new_mode == MODE_EXT_AUTO);
        end
    end

    // Setting registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_reg <= RESTART_RST;
            user_reg <= UBITS_RST;
            rtc_reg <= RTC_DATE_RST[23:0];
            delay_reg <= DELAY_RST;
        end else if (wr_pend_reg) begin
            if (addr_reg == {24'h00_0000, OFF_RESTART}) begin
                restart_reg <= hwdata;
            end
            if (wr_ubits && date_mode) begin
                user_reg[7:0] <= hwdata[7:0];
            end else if (wr_ubits) begin
                user_reg <= hwdata;
            end
            if (addr_reg == {24'h00_0000, OFF_RTC_DATE}) begin
                rtc_reg <= hwdata[23:0];
            end
            if (addr_reg == {24'h00_0000, OFF_DELAY}) begin
                delay_reg <= hwdata > 32'(DELAY_MAX) ? DELAY_MAX : hwdata[6:0];
            end
        end
    end

    // Read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (addr_reg[31:8] == 24'h00_0000) begin
            unique case (addr_reg[7:0])
                OFF_CTRL: begin
                    rd_data[CTRL_MODE_LSB +: 3] = mode_reg;
                    rd_data[CTRL_RATE_LSB +: 3] = rate_reg;
                    rd_data[CTRL_UMODE_LSB +: 2] = umode_reg;
                    rd_data[CTRL_SYNC_BIT] = sync_en_reg;
                    rd_data[CTRL_CONT_BIT] = cont_en_reg;
                end
                OFF_RESTART: rd_data = restart_reg;
                OFF_UBITS: rd_data = user_reg;
                OFF_RTC_DATE: rd_data = {8'h00, rtc_reg};
                OFF_DELAY: rd_data = {25'h000_0000, delay_reg};
                OFF_TC_NOW: rd_data = tc_reg;
                OFF_EXT_TC: rd_data = ext_last_reg;
                OFF_STATUS: begin
                    rd_data[STAT_PRESENT_BIT] = ext_present_reg;
                    rd_data[STAT_RECORD_BIT] = record_req;
                    rd_data[STAT_AUDIO_BIT] = audio_clk_ext;
                    rd_data[STAT_RUN_BIT] = tc_running;
                end
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    // Read data in the wait-state cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata <= rd_data;
        end
    end

    // Incoming timecode capture and loss timeout
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_last_reg <= 32'h0000_0000;
            loss_cnt_reg <= 32'h0000_0000;
            ext_present_reg <= 1'b0;
        end else if (ext_tc_valid) begin
            ext_last_reg <= ext_tc_value;
            loss_cnt_reg <= 32'(LOSS_CYC);
            ext_present_reg <= 1'b1;
        end else begin
            if (loss_cnt_reg != 32'h0000_0000) begin
                loss_cnt_reg <= loss_cnt_reg - 32'h0000_0001;
            end
            ext_present_reg <= loss_cnt_reg > 32'h0000_0001;
        end
    end

    // Which modes let the frame clock run
    always_comb begin
        unique case (mode_reg)
            MODE_INT_FREE, MODE_INT_RTC: run = 1'b1;
            MODE_INT_REC: run = rec_active;
            MODE_EXT, MODE_EXT_AUTO: run = cont_en_reg && !ext_present_reg;
            default: run = 1'b0;
        endcase
    end

    tcg_frame_tick #(
        .CLK_HZ(CLK_HZ)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .rate(rate_reg),
        .tick(frame_tick)
    );

    // One frame step with rate limits, drop frame and rollover
    function automatic tcg_tc_s tc_step(input tcg_tc_s t, input tcg_rate_e r);
        tcg_tc_s n;
        logic [4:0] fmax;
        n = t;
        unique case (r)
            RATE_23976, RATE_24: fmax = FF_MAX_24;
            RATE_25: fmax = FF_MAX_25;
            default: fmax = FF_MAX_30;
        endcase
        if (t.ff < fmax) begin
            n.ff = t.ff + 5'h01;
        end else begin
            n.ff = 5'h00;
            if (t.ss < MS_MAX) begin
                n.ss = t.ss + 6'h01;
            end else begin
                n.ss = 6'h00;
                if (t.mm < MS_MAX) begin
                    n.mm = t.mm + 6'h01;
                end else begin
                    n.mm = 6'h00;
                    n.hh = t.hh < HH_MAX ? t.hh + 5'h01 : 5'h00;
                end
                if (r == RATE_NTSC_DROP && (n.mm % 6'h0a) != 6'h00) begin
                    n.ff = FF_DROP_FIRST;
                end
            end
        end
        return n;
    endfunction

    // Timecode counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tc_reg <= 32'h0000_0000;
        end else if (wr_jam) begin
            tc_reg <= ext_last_reg;
        end else if (wr_restart) begin
            tc_reg <= restart_reg;
        end else if (ext_mode && ext_tc_valid) begin
            tc_reg <= ext_tc_value;
        end else if (frame_tick) begin
            tc_reg <= tc_step(tc_reg, rate_reg);
        end
    end

    assign tc_out = tc_reg;

    // User bits assembly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ubits_out <= 32'h0000_0000;
        end else begin
            unique case (umode_reg)
                UB_FREE: ubits_out <= user_reg;
                UB_MDY: ubits_out <= {rtc_reg[15:8], rtc_reg[7:0], rtc_reg[23:16],
                    user_reg[7:0]};
                UB_DMY: ubits_out <= {rtc_reg[7:0], rtc_reg[15:8], rtc_reg[23:16],
                    user_reg[7:0]};
                UB_YMD: ubits_out <= {rtc_reg[23:16], rtc_reg[15:8], rtc_reg[7:0],
                    user_reg[7:0]};
            endcase
        end
    end

    // Auto record presence timer in tenths of a second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= 32'h0000_0000;
            tenths_reg <= 7'h00;
        end else if (mode_reg != MODE_EXT_AUTO || !ext_present_reg) begin
            pre_reg <= 32'h0000_0000;
            tenths_reg <= 7'h00;
        end else if (pre_reg == 32'(TENTH_CYC - 1)) begin
            pre_reg <= 32'h0000_0000;
            if (tenths_reg < DELAY_MAX) begin
                tenths_reg <= tenths_reg + 7'h01;
            end
        end else begin
            pre_reg <= pre_reg + 32'h0000_0001;
        end
    end

    // Status outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            record_req <= 1'b0;
            audio_clk_ext <= 1'b0;
            tc_running <= 1'b0;
        end else begin
            record_req <= mode_reg == MODE_EXT_AUTO && ext_present_reg
                && tenths_reg >= delay_reg;
            audio_clk_ext <= sync_en_reg && ext_mode && ext_present_reg;
            tc_running <= run || (ext_mode && ext_present_reg);
        end
    end

    a_audio_fallback: assert property (!ext_present_reg |=> !audio_clk_ext)
        else $error("audio clock follows absent timecode");
    a_option_gating: assert property (!ext_mode |-> !sync_en_reg && !cont_en_reg)
        else $error("external option set outside external modes");
    a_fallback_run: assert property (ext_mode && cont_en_reg && !ext_present_reg
        && frame_tick && !wr_jam && !wr_restart && !ext_tc_valid |=> tc_reg != $past(tc_reg))
        else $error("fallback counter did not advance");
    a_date_lock: assert property (wr_ubits && date_mode
        |=> user_reg[31:8] == $past(user_reg[31:8]))
        else $error("date pair modified");
    a_jam_load: assert property (wr_jam |=> tc_reg == $past(ext_last_reg))
        else $error("jam did not load incoming value");
    a_restart_load: assert property (!wr_jam && wr_restart
        |=> tc_reg == $past(restart_reg))
        else $error("restart did not load stored value");
    a_rec_delay: assert property ($rose(record_req)
        |-> $past(tenths_reg) >= $past(delay_reg) && $past(ext_present_reg))
        else $error("record started before delay");
    a_delay_range: assert property (delay_reg <= DELAY_MAX)
        else $error("delay above 8.0 s");
    a_rec_stop: assert property (!ext_present_reg |=> !record_req)
        else $error("recording kept after timecode stop");
    a_drop_skip: assert property (frame_tick && !wr_jam && !wr_restart
        && !(ext_mode && ext_tc_valid) && rate_reg == RATE_NTSC_DROP
        && tc_reg.ff == FF_MAX_30 && tc_reg.ss == MS_MAX && tc_reg.mm == 6'h00
        |=> tc_reg.ff == FF_DROP_FIRST && tc_reg.mm == 6'h01)
        else $error("drop frame numbers not skipped");
    a_day_rollover: assert property (frame_tick && !wr_jam && !wr_restart
        && !(ext_mode && ext_tc_valid) && rate_reg == RATE_25 && tc_reg.hh == HH_MAX
        && tc_reg.mm == MS_MAX && tc_reg.ss == MS_MAX && tc_reg.ff == FF_MAX_25
        |=> tc_reg == 32'h0000_0000)
        else $error("no rollover at end of day");
endmodule // tcg_core
`default_nettype wire

// [tcg_ext_src.sv]
`timescale 1ns/1ps
`default_nettype none
module tcg_ext_src #(
    parameter int PERIOD = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    output logic valid,
    output tcg_pkg::tcg_tc_s value
);
    import tcg_pkg::*;
    int cnt;
    tcg_tc_s cur;
    // Frame pacing; the value line toggles between frames
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            valid <= 1'b0;
            cur <= 32'h0102_0300;
            value <= '0;
        end else begin
            valid <= 1'b0;
            value <= ~value;
            if (run) begin
                cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
                if (cnt == PERIOD - 1) begin
                    valid <= 1'b1;
                    value <= cur;
                    cur.ff <= (cur.ff == 5'h1d) ? 5'h00 : cur.ff + 5'h01;
                end
            end
        end
    end
endmodule // tcg_ext_src
`default_nettype wire

// [tcg_frame_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module tcg_frame_tick #(
    parameter int CLK_HZ = tcg_pkg::CLK_HZ_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire tcg_pkg::tcg_rate_e rate,
    output logic tick
);
    import tcg_pkg::*;

    localparam logic [47:0] THRESH = 48'(longint'(CLK_HZ) * FRAC_SCALE);

    logic [47:0] inc;
    logic [47:0] acc_reg;
    logic [47:0] acc_sum;

    // Phase step for the chosen frame rate
    always_comb begin
        unique case (rate)
            RATE_23976: inc = INC_23976;
            RATE_24: inc = INC_24;
            RATE_25: inc = INC_25;
            RATE_2997, RATE_NTSC_DROP: inc = INC_2997;
            RATE_30: inc = INC_30;
            RATE_3003: inc = INC_3003;
            default: inc = INC_30;
        endcase
    end

    assign acc_sum = acc_reg + inc;

    // Fractional accumulator, one pulse per frame period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg <= 48'h0000_0000_0000;
            tick <= 1'b0;
        end else if (!run) begin
            acc_reg <= 48'h0000_0000_0000;
            tick <= 1'b0;
        end else if (acc_sum >= THRESH) begin
            acc_reg <= acc_sum - THRESH;
            tick <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick <= 1'b0;
        end
    end
endmodule // tcg_frame_tick
`default_nettype wire

// [tcg_pkg.sv]
`default_nettype none
package tcg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_RESTART = 8'h08;
    localparam logic [7:0] OFF_UBITS = 8'h0c;
    localparam logic [7:0] OFF_RTC_DATE = 8'h10;
    localparam logic [7:0] OFF_DELAY = 8'h14;
    localparam logic [7:0] OFF_TC_NOW = 8'h18;
    localparam logic [7:0] OFF_EXT_TC = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RATE_LSB = 4;
    localparam int CTRL_UMODE_LSB = 8;
    localparam int CTRL_SYNC_BIT = 12;
    localparam int CTRL_CONT_BIT = 13;
    localparam int CMD_JAM_BIT = 0;
    localparam int CMD_RESTART_BIT = 1;
    localparam int STAT_PRESENT_BIT = 0;
    localparam int STAT_RECORD_BIT = 1;
    localparam int STAT_AUDIO_BIT = 2;
    localparam int STAT_RUN_BIT = 3;
    // Reset values
    localparam logic [31:0] RESTART_RST = 32'h0000_0000;
    localparam logic [31:0] UBITS_RST = 32'h0000_0000;
    localparam logic [31:0] RTC_DATE_RST = 32'h0000_0101;
    localparam logic [6:0] DELAY_RST = 7'h00;
    // Timing
    localparam int CLK_HZ_DEF = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int DELAY_STEP_MS = 100;
    localparam logic [6:0] DELAY_MAX = 7'h50;
    localparam int LOSS_MS_DEF = 100;
    localparam longint FRAC_SCALE = 1_001_000;
    // Phase increments per clock, in units of 1/(CLK_HZ x FRAC_SCALE) frame
    localparam logic [47:0] INC_23976 = 48'h0000_016e_3600;
    localparam logic [47:0] INC_24 = 48'h0000_016e_93c0;
    localparam logic [47:0] INC_25 = 48'h0000_017d_d9e8;
    localparam logic [47:0] INC_2997 = 48'h0000_01c9_c380;
    localparam logic [47:0] INC_30 = 48'h0000_01ca_38b0;
    localparam logic [47:0] INC_3003 = 48'h0000_01ca_adfe;
    // Frame limits
    localparam logic [4:0] FF_MAX_24 = 5'h17;
    localparam logic [4:0] FF_MAX_25 = 5'h18;
    localparam logic [4:0] FF_MAX_30 = 5'h1d;
    localparam logic [4:0] FF_DROP_FIRST = 5'h02;
    localparam logic [5:0] MS_MAX = 6'h3b;
    localparam logic [4:0] HH_MAX = 5'h17;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_INT_FREE = 3'b001,
        MODE_INT_REC = 3'b010,
        MODE_INT_RTC = 3'b011,
        MODE_EXT = 3'b100,
        MODE_EXT_AUTO = 3'b101
    } tcg_mode_e;

    typedef enum logic [2:0] {
        RATE_23976 = 3'b000,
        RATE_24 = 3'b001,
        RATE_25 = 3'b010,
        RATE_2997 = 3'b011,
        RATE_NTSC_DROP = 3'b100,
        RATE_30 = 3'b101,
        RATE_3003 = 3'b110
    } tcg_rate_e;

    typedef enum logic [1:0] {
        UB_FREE = 2'b00,
        UB_MDY = 2'b01,
        UB_DMY = 2'b10,
        UB_YMD = 2'b11
    } tcg_umode_e;

    // Timecode word layout
    typedef struct packed {
        logic [2:0] pad_h;
        logic [4:0] hh;
        logic [1:0] pad_m;
        logic [5:0] mm;
        logic [1:0] pad_s;
        logic [5:0] ss;
        logic [2:0] pad_f;
        logic [4:0] ff;
    } tcg_tc_s;
endpackage
`default_nettype wire

// [timecode_generator_chase_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module timecode_generator_chase_tb;
    import tcg_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rec_active, src_run;
    logic ext_tc_valid, tc_running, record_req, audio_clk_ext;
    logic [31:0] haddr, hwdata, hrdata, ubits_out, rd, last_ext;
    logic [1:0] htrans;
    logic [2:0] hsize;
    tcg_tc_s ext_tc_value, tc_out;
    int miscompares = 0;
    int checks_done = 0;
    logic [31:0] ub_exp [1:3] = '{32'h0517_2377, 32'h1705_2377, 32'h2305_1777};
    logic [4:0] ff_max [0:6] = '{5'h17, 5'h17, 5'h18, 5'h1d, 5'h1d, 5'h1d, 5'h1d};

    tcg_core #(.CLK_HZ(1000), .LOSS_MS(100)) tcg_core_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ext_tc_valid,
        .ext_tc_value, .rec_active, .tc_out, .ubits_out, .tc_running,
        .record_req, .audio_clk_ext
    );
    tcg_ext_src #(.PERIOD(20)) tcg_ext_src_i (
        .hclk, .hresetn, .run(src_run), .valid(ext_tc_valid), .value(ext_tc_value)
    );

    // Clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Last frame offered by the source
    always @(posedge hclk) begin
        if (ext_tc_valid === 1'b1) last_ext <= ext_tc_value;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // One single AHB transfer, held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        xfer(1'b0, a, 32'h0000_0000, rd);
        chk(nm, ex, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_change;
        logic [31:0] prev;
        prev = tc_out;
        for (int i = 0; i < 300 && tc_out === prev; i++) @(posedge hclk);
        chk("frame_tick", 32'h1, {31'h0, tc_out !== prev});
    endtask

    task automatic wait_pulse;
        for (int i = 0; i < 100 && ext_tc_valid !== 1'b1; i++) @(posedge hclk);
        @(posedge hclk);
    endtask

    task automatic t_regs;
        rchk("ctrl_rst", OFF_CTRL, 32'h0000_0050);
        rchk("date_rst", OFF_RTC_DATE, 32'h0000_0101);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        wr(OFF_DELAY, 32'h0000_0064);
        rchk("delay_clip", OFF_DELAY, 32'h0000_0050);
        wr(OFF_DELAY, 32'h0000_00c8);
        rchk("delay_wide", OFF_DELAY, 32'h0000_0050);
        wr(OFF_CTRL, 32'h0000_3011);
        rchk("opt_gate", OFF_CTRL, 32'h0000_0011);
        wr(OFF_CTRL, 32'h0000_0076);
        rchk("mode_bad", OFF_CTRL, 32'h0000_0010);
    endtask

    // Record-run mode follows the recorder, RTC mode runs free
    task automatic t_recrun;
        logic [31:0] held;
        wr(OFF_CTRL, 32'h0000_0052);
        cyc(2);
        held = tc_out;
        cyc(80);
        chk("rec_stop", held, tc_out);
        chk("rec_idle", 32'h0, {31'h0, tc_running});
        rec_active <= 1'b1;
        wait_change;
        rec_active <= 1'b0;
        wr(OFF_CTRL, 32'h0000_0053);
        wait_change;
    endtask

    task automatic t_ubits;
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_UBITS, 32'h12ab_34cd);
        cyc(2);
        chk("ubits_free", 32'h12ab_34cd, ubits_out);
        wr(OFF_RTC_DATE, 32'h0023_0517);
        for (int m = 1; m <= 3; m++) begin
            wr(OFF_CTRL, 32'(m) << 8);
            wr(OFF_UBITS, 32'hffff_ff77);
            cyc(2);
            chk("ubits_date", ub_exp[m], ubits_out);
        end
    endtask

    // Load a value by restart, run free, check the next frame
    task automatic roll(input logic [2:0] r, input logic [31:0] st, input logic [31:0] ex);
        wr(OFF_CTRL, {25'h0, r, 4'h0});
        wr(OFF_RESTART, st);
        wr(OFF_CMD, 32'h0000_0002);
        cyc(2);
        chk("restart", st, tc_out);
        wr(OFF_CTRL, {25'h0, r, 4'h1});
        wait_change;
        chk("next_frame", ex, tc_out);
    endtask

    task automatic t_count;
        for (int r = 0; r < 7; r++) begin
            roll(3'(r), 32'h173b_3b00 | ff_max[r], 32'h0000_0000);
        end
        roll(3'h4, 32'h0000_3b1d, 32'h0001_0002);
        roll(3'h4, 32'h0009_3b1d, 32'h000a_0000);
        roll(3'h5, 32'h0000_3b1d, 32'h0001_0000);
    endtask

    task automatic t_jam;
        wr(OFF_CTRL, 32'h0000_0050);
        src_run <= 1'b1;
        cyc(45);
        src_run <= 1'b0;
        cyc(3);
        rchk("ext_tc", OFF_EXT_TC, last_ext);
        wr(OFF_CMD, 32'h0000_0001);
        cyc(2);
        chk("jam", last_ext, tc_out);
    endtask

    task automatic t_chase;
        wr(OFF_CTRL, 32'h0000_3054);
        rchk("opt_ext", OFF_CTRL, 32'h0000_3054);
        src_run <= 1'b1;
        repeat (3) begin
            wait_pulse;
            @(posedge hclk);
            chk("chase", last_ext, tc_out);
        end
        cyc(2);
        chk("audio_ext", 32'h1, {31'h0, audio_clk_ext});
        src_run <= 1'b0;
        cyc(130);
        chk("audio_int", 32'h0, {31'h0, audio_clk_ext});
        chk("fallback", 32'h1, {31'h0, tc_running});
        wait_change;
    endtask

    task automatic t_auto;
        wr(OFF_DELAY, 32'h0000_0002);
        wr(OFF_CTRL, 32'h0000_0055);
        src_run <= 1'b1;
        cyc(60);
        src_run <= 1'b0;
        cyc(200);
        chk("burst", 32'h0, {31'h0, record_req});
        src_run <= 1'b1;
        cyc(150);
        chk("early", 32'h0, {31'h0, record_req});
        cyc(100);
        chk("rec_on", 32'h1, {31'h0, record_req});
        src_run <= 1'b0;
        cyc(125);
        chk("rec_off", 32'h0, {31'h0, record_req});
    endtask

    // Watchdog
    initial begin
        repeat (30000) @(posedge hclk);
        miscompares++;
        stop_test;
    end

    initial begin
        {hresetn, hsel, hwrite, rec_active, src_run} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        cyc(3);
        hresetn <= 1'b1;
        cyc(1);
        t_regs;
        t_ubits;
        t_count;
        t_recrun;
        t_jam;
        t_chase;
        t_auto;
        stop_test;
    end
endmodule // timecode_generator_chase_tb
`default_nettype wire
